//--- lst_map.vh
/*
 * Constants for the learn string framer: register offsets, field positions,
 * command codes, string layout positions and byte counts.
 * Assumes inclusion by bare name from the framer and its CRC engine.
 */
`ifndef LST_MAP_VH
`define LST_MAP_VH

// register byte offsets on the wishbone slave
`define LST_REG_CTRL 8'h00
`define LST_REG_STATUS 8'h04
`define LST_REG_STATE_CFG 8'h08
`define LST_REG_TRACE 8'h0C
`define LST_REG_TIMING 8'h10
`define LST_REG_TOTAL 8'h14

// reset values
`define LST_STATE_CFG_RST 32'h0000_3900
`define LST_TRACE_RST 32'h0000_0000
`define LST_TIMING_RST 32'h0000_0000

// control register command field values
`define LST_CMD_CONFIG 3'h1
`define LST_CMD_STATE 3'h2
`define LST_CMD_TIMING 3'h3
`define LST_CMD_EVERYTHING 3'h4
`define LST_CMD_TEXT_END 3'h5

// state config register field positions
`define LST_SC_LABEL 0
`define LST_SC_TPOS 1
`define LST_SC_CALL 2
`define LST_SC_FPC 3
`define LST_SC_PACT 4
`define LST_SC_CHAN_LO 8
`define LST_SC_RNG_LO 16

// string kinds
`define LST_K_CONFIG 2'h0
`define LST_K_STATE 2'h1
`define LST_K_TIMING 2'h2

// two-character command codes
`define LST_CFG_CODE0 8'h52
`define LST_CFG_CODE1 8'h43
`define LST_STA_CODE0 8'h41
`define LST_STA_CODE1 8'h53
`define LST_TIM_CODE0 8'h52
`define LST_TIM_CODE1 8'h54

// string layout positions (1 based)
`define LST_POS_CNT_HI 16'h0003
`define LST_POS_CNT_LO 16'h0004
`define LST_POS_CRC_START 16'h0005
`define LST_POS_TPOS 16'h000C
`define LST_POS_CALL 16'h000D
`define LST_POS_FPC 16'h000E
`define LST_POS_PACT 16'h0013
`define LST_POS_TYPE 16'h0014
`define LST_POS_CHAN 16'h0015
`define LST_POS_VALID_HI 16'h0016
`define LST_POS_VALID_LO 16'h0017
`define LST_POS_TP_HI 16'h0018
`define LST_POS_TP_LO 16'h0019

// byte counts and sizes
`define LST_CFG_COUNT 16'h1564
`define LST_CFG_TAIL 16'h0001
`define LST_TRC_OVERHEAD 16'h0019
`define LST_TRC_TAIL 16'h0001
`define LST_TRC_MAX57 16'h1639
`define LST_TRC_MAX65 16'h183C
`define LST_CHAN57 8'h39
`define LST_CHAN65 8'h41
`define LST_M57 4'hB
`define LST_M65 4'hC
`define LST_LBL_COUNT 16'h0118
`define LST_LBL_RANGE_BYTES 16'h0017
`define LST_LBL_RANGES 4'h8
`define LST_TE_MAX 32'h0000_10BC

// data type codes
`define LST_TYPE_TRACE 8'h00
`define LST_TYPE_LABEL 8'h01

// text terminator
`define LST_CR 8'h0D
`define LST_LF 8'h0A

// crc engine defaults
`define LST_CRC_POLY 16'h8005
`define LST_CRC_INIT 16'h0000

`endif

//--- lst_crc.v
/*
 * Replaceable 16-bit CRC engine, one byte per enable, MSB first.
 * Assumes the framer clears it before each string and feeds only window bytes.
 */
`timescale 1ns/100ps
`include "lst_map.vh"

module lst_crc #(
   parameter [15:0] POLY = `LST_CRC_POLY,
   parameter [15:0] INIT = `LST_CRC_INIT
) (
   input wire clk_i, // system clock
   input wire rst_i, // synchronous reset, high
   input wire clr_i, // reload initial value
   input wire en_i, // fold in one byte
   input wire [7:0] data_i, // byte to fold in
   output wire [15:0] crc_o // running remainder
);
   reg [15:0] crc_q;
   reg [15:0] crc_d;
   integer i;

   // bitwise lfsr over the incoming byte
   always @* begin
      crc_d = crc_q;
      for (i = 7; i >= 0; i = i - 1) begin
         if (crc_d[15] ^ data_i[i]) begin
            crc_d = {crc_d[14:0], 1'b0} ^ POLY;
         end else begin
            crc_d = {crc_d[14:0], 1'b0};
         end
      end
   end

   // remainder register
   always @(posedge clk_i) begin
      if (rst_i || clr_i) begin
         crc_q <= INIT;
      end else if (en_i) begin
         crc_q <= crc_d;
      end
   end

   assign crc_o = crc_q;
endmodule // lst_crc

//--- lst_framer.v
/*
 * Learn string framer: builds configuration, state and timing learn strings
 * with command code, big-endian count, CRC-covered payload and CRC bytes,
 * and the transmit-everything sequence, onto a byte link with EOI.
 * Assumes a payload source and a bus handshake engine on the same clock,
 * and a classic wishbone master for the registers.
 */
`timescale 1ns/100ps
`include "lst_map.vh"

// Behaviour
// - transmit-everything sends configuration, then state, then timing strings back to back
// - total transmit-everything length is the sum of the three strings
// - binary transfer ends with EOI on its final byte
// - non-binary transfer ends with CR LF, EOI on the terminator
// - configuration string: receive-config code at byte 1, count at byte 3
// - configuration data from byte 5, revision byte outside CRC, CRC bytes follow
// - configuration count is always 5476
// - count holds bytes following it, CRC bytes included; the configuration count here is two more than the bytes that follow it
// - count is sent most significant byte first
// - upper seven bits of state MSB internal, low bits carry top probe channels
// - state string: accept-state code at byte 1, count at byte 3, CRC from byte 5
// - status flags at 12, 13, 14, period at 15, program activity at 19
// - byte 20 type code, zero means state trace
// - trace: channels at 21, valid count at 22, tracepoint at 24, data at 27
// - trace data length is valid states times 0, 11 or 12 bytes
// - trace CRC stops at end of data, CRC bytes at data length plus 28
// - trace count never exceeds 5689 or 6204 by channel count, string four bytes more
// - type one marks label overview, eight internal bytes from byte 21
// - up to eight range records from byte 29, shortened for fewer ranges
// - range record: internal, sample count, end, start address, five-char name
// - assignment label at 261, totals at 275 and 279
// - label overview CRC at 283, count at most 280
module lst_framer (
   input wire clk_i, // system clock, 125 MHz
   input wire rst_i, // synchronous reset, high
   input wire wb_cyc_i, // wishbone cycle
   input wire wb_stb_i, // wishbone strobe
   input wire wb_we_i, // wishbone write enable
   input wire [7:0] wb_adr_i, // wishbone byte address
   input wire [3:0] wb_sel_i, // wishbone byte enables
   input wire [31:0] wb_dat_i, // wishbone write data
   output reg [31:0] wb_dat_o, // wishbone read data
   output reg wb_ack_o, // wishbone acknowledge
   input wire src_valid_i, // payload byte available
   input wire [7:0] src_data_i, // payload byte
   output reg src_ready_o, // payload byte taken when both high
   output reg [15:0] src_pos_o, // string position of requested byte
   output reg [1:0] src_kind_o, // string kind being built
   output reg [7:0] tx_data_o, // byte to the bus engine
   output reg tx_eoi_o, // end marker with this byte
   output reg tx_valid_o, // byte offered
   input wire tx_ready_i // bus engine takes the byte
);
   localparam S_IDLE = 2'h0;
   localparam S_RUN = 2'h1;
   localparam S_CR = 2'h2;
   localparam S_LF = 2'h3;

   reg [1:0] state_q, state_d;
   reg [1:0] kind_q, kind_d;
   reg [15:0] pos_q, pos_d;
   reg seq_q, seq_d;
   reg [31:0] total_q, total_d;
   reg [7:0] txd_d;
   reg txe_d, txv_d;
   reg src_ready_d;
   reg start_q;
   reg [2:0] cmd_q;
   reg [31:0] scfg_q;
   reg [31:0] trace_q;
   reg [31:0] timing_q;
   reg crc_clr, crc_en;
   reg [7:0] loc_byte;
   wire [15:0] crc;
   wire wb_req;
   wire busy;

   // field views of the software registers
   wire sc_label = scfg_q[`LST_SC_LABEL];
   wire [7:0] sc_chan = scfg_q[`LST_SC_CHAN_LO +: 8];
   wire [3:0] sc_rng = scfg_q[`LST_SC_RNG_LO +: 4];
   wire [15:0] tr_valid = trace_q[15:0];
   wire [15:0] tr_tp = trace_q[31:16];

   // byte count of a string of the given kind
   function [15:0] f_count;
      input [1:0] k;
      reg [3:0] m;
      reg [3:0] rng;
      reg [19:0] n;
      reg [19:0] full;
      reg [15:0] lim;
      begin
         m = 4'h0;
         lim = `LST_TRC_MAX65;
         if (sc_chan == `LST_CHAN57) begin
            m = `LST_M57;
            lim = `LST_TRC_MAX57;
         end else if (sc_chan == `LST_CHAN65) begin
            m = `LST_M65;
         end
         n = tr_valid * m;
         full = n + {4'h0, `LST_TRC_OVERHEAD};
         rng = (sc_rng > `LST_LBL_RANGES) ? `LST_LBL_RANGES : sc_rng;
         case (k)
            `LST_K_CONFIG: f_count = `LST_CFG_COUNT;
            `LST_K_STATE: begin
               if (sc_label) begin
                  // each missing range shortens the block by one record
                  f_count = `LST_LBL_COUNT - `LST_LBL_RANGE_BYTES * {12'h000, `LST_LBL_RANGES - rng};
               end else if (full > {4'h0, lim}) begin
                  f_count = lim;
               end else begin
                  f_count = full[15:0];
               end
            end
            `LST_K_TIMING: f_count = timing_q[15:0] + 16'h0002;
            default: f_count = 16'h0000;
         endcase
      end
   endfunction

   // payload bytes at the end of the string that lie outside the CRC window
   function [15:0] f_tail;
      input [1:0] k;
      begin
         if (k == `LST_K_CONFIG) begin
            f_tail = `LST_CFG_TAIL;
         end else if (k == `LST_K_STATE && !sc_label) begin
            f_tail = `LST_TRC_TAIL;
         end else begin
            f_tail = 16'h0000;
         end
      end
   endfunction

   // positions that the framer fills itself rather than the source
   function f_local;
      input [1:0] k;
      input [15:0] p;
      begin
         f_local = 1'b0;
         if (p < `LST_POS_CRC_START) begin
            f_local = 1'b1;
         end else if (k == `LST_K_STATE) begin
            if (p == `LST_POS_TPOS || p == `LST_POS_CALL || p == `LST_POS_FPC ||
                p == `LST_POS_PACT || p == `LST_POS_TYPE) begin
               f_local = 1'b1;
            end else if (!sc_label && p >= `LST_POS_CHAN && p <= `LST_POS_TP_LO) begin
               f_local = 1'b1;
            end
         end
      end
   endfunction

   wire [15:0] count_cur = f_count(kind_q);
   // the configuration count already spans its crc bytes, the other strings add them
   wire [15:0] last_pay = (kind_q == `LST_K_CONFIG) ? count_cur : count_cur + 16'h0002;
   wire [15:0] crc_end = last_pay - f_tail(kind_q);
   wire [15:0] last_pos = last_pay + 16'h0002;
   wire is_local = f_local(kind_q, pos_q);
   wire in_win = (pos_q >= `LST_POS_CRC_START) && (pos_q <= crc_end);
   wire [15:0] last_pay_d = (kind_d == `LST_K_CONFIG) ? f_count(kind_d) : f_count(kind_d) + 16'h0002;

   // bytes the framer produces: code, count and state header fields
   always @* begin
      loc_byte = 8'h00;
      case (pos_q)
         16'h0001: begin
            loc_byte = (kind_q == `LST_K_CONFIG) ? `LST_CFG_CODE0 :
                       (kind_q == `LST_K_STATE) ? `LST_STA_CODE0 : `LST_TIM_CODE0;
         end
         16'h0002: begin
            loc_byte = (kind_q == `LST_K_CONFIG) ? `LST_CFG_CODE1 :
                       (kind_q == `LST_K_STATE) ? `LST_STA_CODE1 : `LST_TIM_CODE1;
         end
         `LST_POS_CNT_HI: loc_byte = count_cur[15:8];
         `LST_POS_CNT_LO: loc_byte = count_cur[7:0];
         `LST_POS_TPOS: loc_byte = {7'h00, scfg_q[`LST_SC_TPOS]};
         `LST_POS_CALL: loc_byte = {7'h00, scfg_q[`LST_SC_CALL]};
         `LST_POS_FPC: loc_byte = {7'h00, scfg_q[`LST_SC_FPC]};
         `LST_POS_PACT: loc_byte = {7'h00, scfg_q[`LST_SC_PACT]};
         `LST_POS_TYPE: loc_byte = sc_label ? `LST_TYPE_LABEL : `LST_TYPE_TRACE;
         `LST_POS_CHAN: loc_byte = sc_chan;
         `LST_POS_VALID_HI: loc_byte = tr_valid[15:8];
         `LST_POS_VALID_LO: loc_byte = tr_valid[7:0];
         `LST_POS_TP_HI: loc_byte = tr_tp[15:8];
         `LST_POS_TP_LO: loc_byte = tr_tp[7:0];
         default: loc_byte = 8'h00;
      endcase
   end

   assign busy = (state_q != S_IDLE) || tx_valid_o;

   // framing sequencer: next state of every output and counter
   always @* begin
      state_d = state_q;
      kind_d = kind_q;
      pos_d = pos_q;
      seq_d = seq_q;
      total_d = total_q;
      txd_d = tx_data_o;
      txe_d = tx_eoi_o;
      txv_d = tx_valid_o;
      crc_clr = 1'b0;
      crc_en = 1'b0;
      if (tx_valid_o && tx_ready_i) begin
         txv_d = 1'b0;
         txe_d = 1'b0;
         total_d = total_q + 32'h0000_0001;
      end
      case (state_q)
         S_IDLE: begin
            if (start_q && !tx_valid_o) begin
               if (cmd_q == `LST_CMD_TEXT_END) begin
                  state_d = S_CR;
               end else if (cmd_q >= `LST_CMD_CONFIG && cmd_q <= `LST_CMD_EVERYTHING) begin
                  state_d = S_RUN;
                  pos_d = 16'h0001;
                  crc_clr = 1'b1;
                  total_d = 32'h0000_0000;
                  seq_d = (cmd_q == `LST_CMD_EVERYTHING);
                  case (cmd_q)
                     `LST_CMD_STATE: kind_d = `LST_K_STATE;
                     `LST_CMD_TIMING: kind_d = `LST_K_TIMING;
                     default: kind_d = `LST_K_CONFIG;
                  endcase
               end
            end
         end
         S_RUN: begin
            if (!tx_valid_o) begin
               if (is_local && pos_q <= last_pay) begin
                  txv_d = 1'b1;
                  txd_d = loc_byte;
                  crc_en = in_win;
                  pos_d = pos_q + 16'h0001;
               end else if (pos_q <= last_pay) begin
                  // source data passes unchanged, state MSB internal bits included
                  if (src_ready_o && src_valid_i) begin
                     txv_d = 1'b1;
                     txd_d = src_data_i;
                     crc_en = in_win;
                     pos_d = pos_q + 16'h0001;
                  end
               end else begin
                  txv_d = 1'b1;
                  txd_d = (pos_q == last_pos) ? crc[7:0] : crc[15:8];
                  pos_d = pos_q + 16'h0001;
                  if (pos_q == last_pos) begin
                     // only the very last byte of the transfer carries the end marker
                     txe_d = !(seq_q && kind_q != `LST_K_TIMING);
                     pos_d = 16'h0001;
                     crc_clr = 1'b1;
                     if (seq_q && kind_q == `LST_K_CONFIG) begin
                        kind_d = `LST_K_STATE;
                     end else if (seq_q && kind_q == `LST_K_STATE) begin
                        kind_d = `LST_K_TIMING;
                     end else begin
                        state_d = S_IDLE;
                        seq_d = 1'b0;
                     end
                  end
               end
            end
         end
         S_CR: begin
            if (!tx_valid_o) begin
               txv_d = 1'b1;
               txd_d = `LST_CR;
               txe_d = 1'b0;
               state_d = S_LF;
            end
         end
         S_LF: begin
            if (!tx_valid_o) begin
               txv_d = 1'b1;
               txd_d = `LST_LF;
               txe_d = 1'b1;
               state_d = S_IDLE;
            end
         end
         default: state_d = S_IDLE;
      endcase
      // source may hand over a byte only when the holding slot will be empty
      src_ready_d = (state_d == S_RUN) && !txv_d && (pos_d <= last_pay_d) && !f_local(kind_d, pos_d);
   end

   // sequencer registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         kind_q <= `LST_K_CONFIG;
         pos_q <= 16'h0000;
         seq_q <= 1'b0;
         total_q <= 32'h0000_0000;
         tx_data_o <= 8'h00;
         tx_eoi_o <= 1'b0;
         tx_valid_o <= 1'b0;
         src_ready_o <= 1'b0;
         src_pos_o <= 16'h0000;
         src_kind_o <= `LST_K_CONFIG;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         pos_q <= pos_d;
         seq_q <= seq_d;
         total_q <= total_d;
         tx_data_o <= txd_d;
         tx_eoi_o <= txe_d;
         tx_valid_o <= txv_d;
         src_ready_o <= src_ready_d;
         src_pos_o <= pos_d;
         src_kind_o <= kind_d;
      end
   end

   // replaceable crc engine over the window bytes
   lst_crc #(
      .POLY(`LST_CRC_POLY),
      .INIT(`LST_CRC_INIT)
   ) u_crc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clr_i(crc_clr),
      .en_i(crc_en),
      .data_i(txd_d),
      .crc_o(crc)
   );

   // byte-lane merge for register writes
   function [31:0] f_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer b;
      begin
         f_merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (sel[b]) begin
               f_merge[b*8 +: 8] = nw[b*8 +: 8];
            end
         end
      end
   endfunction

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // wishbone slave: one wait state, writes land with the ack
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         start_q <= 1'b0;
         cmd_q <= 3'h0;
         scfg_q <= `LST_STATE_CFG_RST;
         trace_q <= `LST_TRACE_RST;
         timing_q <= `LST_TIMING_RST;
      end else begin
         wb_ack_o <= wb_req;
         start_q <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && wb_we_i) begin
            case (wb_adr_i)
               `LST_REG_CTRL: begin
                  // a command written while a transfer runs is dropped
                  if (wb_sel_i[0] && !busy) begin
                     start_q <= 1'b1;
                     cmd_q <= wb_dat_i[2:0];
                  end
               end
               `LST_REG_STATE_CFG: scfg_q <= f_merge(scfg_q, wb_dat_i, wb_sel_i);
               `LST_REG_TRACE: trace_q <= f_merge(trace_q, wb_dat_i, wb_sel_i);
               `LST_REG_TIMING: timing_q <= f_merge(timing_q, wb_dat_i, wb_sel_i);
               default: start_q <= 1'b0;
            endcase
         end else if (wb_req) begin
            case (wb_adr_i)
               `LST_REG_CTRL: wb_dat_o <= {29'h0000_0000, cmd_q};
               `LST_REG_STATUS: wb_dat_o <= {pos_q, 11'h000, seq_q, kind_q, state_q != S_IDLE, busy};
               `LST_REG_STATE_CFG: wb_dat_o <= scfg_q;
               `LST_REG_TRACE: wb_dat_o <= trace_q;
               `LST_REG_TIMING: wb_dat_o <= {16'h0000, timing_q[15:0]};
               `LST_REG_TOTAL: wb_dat_o <= total_q;
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // lst_framer

//--- lst_checker_assertions.sv
/* port checker for the learn string framer.
   assumes binding to lst_framer, one clock, synchronous reset. */
`timescale 1ns/100ps
module lst_checker (
   input wire clk_i, // clock
   input wire rst_i, // reset
   input wire wb_cyc_i, // cycle
   input wire wb_stb_i, // strobe
   input wire [31:0] wb_dat_o, // read data
   input wire wb_ack_o, // ack
   input wire src_valid_i, // source has byte
   input wire [7:0] src_data_i, // source byte
   input wire src_ready_o, // source taken
   input wire [15:0] src_pos_o, // wanted position
   input wire [7:0] tx_data_o, // link byte
   input wire tx_eoi_o, // end mark
   input wire tx_valid_o, // byte offered
   input wire tx_ready_i // link takes
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // register bus answers
   a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   // link byte handshake
   a_tx_held: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_eoi_o))
      else $error("link byte changed before taken");
   a_tx_spacing: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
      else $error("link byte offered back to back");
   a_eoi_with_byte: assert property (tx_eoi_o |-> tx_valid_o)
      else $error("end mark without byte");
   // payload source handshake
   a_src_passes: assert property (src_ready_o && src_valid_i |=> tx_valid_o && tx_data_o == $past(src_data_i))
      else $error("payload byte not forwarded");
   a_src_released: assert property (src_ready_o && src_valid_i |=> !src_ready_o)
      else $error("source ready held after take");
   a_src_stable: assert property (src_ready_o && !src_valid_i |=> src_ready_o && $stable(src_pos_o))
      else $error("source request changed while waiting");
   a_no_header_req: assert property (src_ready_o |-> src_pos_o >= 16'h0005)
      else $error("header position asked of source");
   c_eoi_taken: cover property (tx_valid_o && tx_ready_i && tx_eoi_o);
   c_src_take: cover property (src_ready_o && src_valid_i);
   c_tx_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule // lst_checker

bind lst_framer lst_checker u_lst_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_valid_i(src_valid_i),
   .src_data_i(src_data_i), .src_ready_o(src_ready_o), .src_pos_o(src_pos_o), .tx_data_o(tx_data_o),
   .tx_eoi_o(tx_eoi_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));

//--- lst_link_model.sv
/* far-side byte link receiver, prompt or stalling.
   assumes the framer's tx handshake on the same clock. */
`timescale 1ns/100ps
module lst_link_model (
   input wire clk_i, // clock
   input wire rst_i, // reset
   input wire slow_i, // stall mode
   input wire [7:0] tx_data_i, // byte
   input wire tx_eoi_i, // end mark
   input wire tx_valid_i, // offered
   output reg tx_ready_o // take
);
   logic [7:0] rx_q[$];
   int eoi_n = 0;
   int eoi_at = 0;
   logic [1:0] ph_q;
   // ready one cycle in three when stalling
   always @(posedge clk_i) begin
      ph_q <= rst_i || ph_q == 2'h2 ? 2'h0 : ph_q + 2'h1;
      tx_ready_o <= !rst_i && (!slow_i || ph_q == 2'h2);
   end
   // collect bytes; the end-marked byte closes the transfer
   always @(posedge clk_i) begin
      if (!rst_i && tx_valid_i && tx_ready_o) begin
         rx_q.push_back(tx_data_i);
         if (tx_eoi_i) begin
            eoi_n <= eoi_n + 1;
            eoi_at <= rx_q.size() - 1;
         end
      end
   end
endmodule // lst_link_model

//--- lst_framer_test.sv
/* self-checking bench: registers over wishbone, a payload source,
   framed strings checked as seen by the link model. */
`timescale 1ns/100ps
module lst_framer_test;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, src_data_i = 8'h00, cnt_q = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, rd;
   logic src_valid_i = 1'b0, slow = 1'b0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, src_ready_o, tx_eoi_o, tx_valid_o, tx_ready_i;
   wire [15:0] src_pos_o;
   wire [1:0] src_kind_o;
   wire [7:0] tx_data_o;
   int errors = 0, comparisons = 0, n;
   logic [7:0] ch_t[3] = '{8'h39, 8'h41, 8'h00};
   int m_t[3] = '{11, 12, 0};
   logic [3:0] r_t[3] = '{4'h3, 4'h8, 4'hC};
   always #4 clk_i = ~clk_i;
   lst_framer u_lst_framer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .src_valid_i(src_valid_i), .src_data_i(src_data_i), .src_ready_o(src_ready_o),
      .src_pos_o(src_pos_o), .src_kind_o(src_kind_o), .tx_data_o(tx_data_o), .tx_eoi_o(tx_eoi_o),
      .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
   lst_link_model u_lst_link_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .tx_data_i(tx_data_o),
      .tx_eoi_i(tx_eoi_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
   // payload source, idle every other cycle when slow, data always moving
   always @(posedge clk_i) begin
      cnt_q <= cnt_q + 8'h01;
      src_valid_i <= !slow || cnt_q[0];
      src_data_i <= cnt_q ^ 8'h5A;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog against a hung transfer
   initial begin
      #720000;
      errors++;
      stop_test;
   end
   task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      rd = wb_dat_o;
      chk(wb_ack_o, 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   function logic [7:0] b(input int i);
      return u_lst_link_model.rx_q[i];
   endfunction
   function int sz();
      return u_lst_link_model.rx_q.size();
   endfunction
   function logic [15:0] crc(input int a, input int z);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = a; i <= z; i++) begin
         c = c ^ {b(i), 8'h00};
         for (int k = 0; k < 8; k++) c = c[15] ? (c << 1) ^ 16'h8005 : c << 1;
      end
      return c;
   endfunction
   task run(input logic [2:0] cmd, input logic s);
      int k;
      k = 0;
      u_lst_link_model.rx_q.delete();
      u_lst_link_model.eoi_n = 0;
      slow <= s;
      wb(1'b1, 8'h00, {29'h0, cmd});
      while (u_lst_link_model.eoi_n == 0 && k < 40000) begin
         @(posedge clk_i);
         k++;
      end
      repeat (4) @(posedge clk_i);
      chk(u_lst_link_model.eoi_n, 1);
      chk(u_lst_link_model.eoi_at, sz() - 1);
   endtask
   // one string at offset o: code, count, and crc over its window unless tail is negative
   task str(input int o, input logic [15:0] code, input int cnt, input int len, input int tail);
      chk({b(o), b(o + 1)}, code);
      chk({b(o + 2), b(o + 3)}, cnt);
      if (tail >= 0) chk({b(o + len - 2), b(o + len - 1)}, crc(o + 4, o + len - 3 - tail));
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h08, 0);
      chk(rd, 32'h0000_3900);
      wb(1'b0, 8'h0C, 0);
      chk(rd, 0);
      wb(1'b0, 8'h10, 0);
      chk(rd, 0);
      wb(1'b1, 8'h20, 32'hFFFF_FFFF);
      wb(1'b0, 8'h20, 0);
      chk(rd, 0);
      $display("test registers done");
      run(3'h1, 1'b0);
      chk(sz(), 5478);
      str(0, 16'h5243, 5476, 5478, 1);
      wb(1'b0, 8'h14, 0);
      chk(rd, 5478);
      chk(src_kind_o, 2'h0);
      $display("test configuration done");
      wb(1'b1, 8'h0C, 32'h0001_0002);
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, 8'h08, {16'h0, ch_t[i], 8'h00} | (i == 1 ? 32'h1E : 32'h0));
         run(3'h2, i == 1);
         n = 2 * m_t[i];
         chk(sz(), n + 29);
         str(0, 16'h4153, n + 25, n + 29, 1);
         chk(b(19), 0);
         chk(src_kind_o, 2'h1);
         chk(b(20), ch_t[i]);
         chk({b(21), b(22), b(23), b(24)}, 32'h0002_0001);
         chk({b(11) != 0, b(12) != 0, b(13) != 0, b(18) != 0}, i == 1 ? 4'hF : 4'h0);
      end
      $display("test trace done");
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, 8'h08, {12'h0, r_t[i], 16'h3901});
         run(3'h2, 1'b0);
         n = 280 - 23 * (8 - (r_t[i] > 8 ? 8 : r_t[i]));
         chk(sz(), n + 4);
         str(0, 16'h4153, n, n + 4, 0);
         chk(b(19), 1);
      end
      $display("test label overview done");
      wb(1'b1, 8'h08, 32'h3900);
      wb(1'b1, 8'h10, 3);
      fork
         run(3'h4, 1'b1);
         begin
            repeat (300) @(posedge clk_i);
            wb(1'b0, 8'h04, 0);
            chk(rd[0], 1'b1);
            wb(1'b1, 8'h00, 1);
         end
      join
      chk(sz(), 5538);
      str(0, 16'h5243, 5476, 5478, 1);
      str(5478, 16'h4153, 47, 51, 1);
      str(5529, 16'h5254, 5, 9, -1);
      wb(1'b0, 8'h14, 0);
      chk(rd, 5538);
      wb(1'b0, 8'h00, 0);
      chk(rd[2:0], 3'h4);
      $display("test everything done");
      run(3'h5, 1'b0);
      chk(sz(), 2);
      chk({b(0), b(1)}, 16'h0D0A);
      $display("test terminator done");
      stop_test;
   end
endmodule // lst_framer_test
